// File: shared/cpu_decode_pkg.sv
`default_nettype none
package cpu_decode_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register byte addresses; the flags register sits at four times its printed index
  localparam logic [ADDR_W-1:0] OFF_INSTR   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_OPND    = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_DECODE  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_ADDR    = 12'h00C;
  localparam logic [ADDR_W-1:0] FLAGS_INDEX = 12'h0D5;
  localparam logic [ADDR_W-1:0] OFF_FLAGS   = {FLAGS_INDEX[ADDR_W-3:0], 2'b00};

  // Flag bit positions
  localparam int unsigned FLAG_CARRY = 7;
  localparam int unsigned FLAG_ZERO  = 6;
  localparam int unsigned FLAG_SIGN  = 5;
  localparam int unsigned FLAG_OVF   = 4;
  localparam int unsigned FLAG_DEC   = 3;
  localparam int unsigned FLAG_HALF  = 2;
  localparam int unsigned FLAG_FIS   = 1;
  localparam int unsigned FLAG_BANK  = 0;

  // Reset values
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [31:0] INSTR_RESET = 32'h0000_00FF;
  localparam logic [31:0] OPND_RESET  = 32'h0000_0000;

  // Opcodes with their own effects
  localparam logic [7:0] OPC_INTERRUPT_RETURN_INSTR     = 8'hBF;
  localparam logic [7:0] OPC_SB0      = 8'h4F;
  localparam logic [7:0] OPC_SB1      = 8'h5F;
  localparam logic [7:0] OPC_CALL_IA  = 8'hD4;
  localparam logic [7:0] OPC_CALL_IRR = 8'hF4;
  localparam logic [7:0] OPC_CALL_DA  = 8'hF6;
  localparam logic [7:0] OPC_LDW_IML  = 8'hC6;
  localparam logic [7:0] OPC_LDW_RR   = 8'hC4;
  localparam logic [7:0] OPC_CPIJE    = 8'hC2;
  localparam logic [7:0] OPC_CPIJNE   = 8'hD2;

  // Register byte whose upper nibble is this names a working register
  localparam logic [3:0] WREG_PREFIX = 4'hC;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    m_none, m_work, m_work_bit, m_reg, m_reg_pair, m_ind_addr, m_ind_pair,
    m_indexed, m_short_idx, m_long_idx, m_direct, m_relative, m_imm_byte,
    m_imm_long
  } mode_e;

  typedef enum logic [3:0] {
    alu_add, alu_adc, alu_sub, alu_sbc, alu_or, alu_and, alu_tcm, alu_tm,
    alu_cp, alu_xor, alu_none
  } alu_e;

  typedef enum logic [2:0] {
    f_none, f_work_work, f_work_ind, f_reg_reg, f_ind_reg, f_reg_imm
  } form_e;

  typedef struct packed {
    logic       err;
    mode_e      mode;
    alu_e       alu;
    form_e      form;
    logic [3:0] wreg;
    logic [2:0] bitpos;
    logic       valid;
  } dec_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage
`default_nettype wire

// File: design/operand_address_unit.sv
`timescale 1ns/1ps
`default_nettype none
module operand_address_unit (
  input  wire cpu_decode_pkg::mode_e mode,
  input  wire logic [7:0]            b1,
  input  wire logic [7:0]            b2,
  input  wire logic [7:0]            b3,
  input  wire logic [15:0]           opnd_val,
  input  wire logic [15:0]           pc_next,
  output var  logic [15:0]           eff_addr,
  output var  logic [15:0]           imm,
  output var  logic                  err
);

  logic [15:0] disp8;

  always_comb begin
    disp8    = {{8{b2[7]}}, b2};
    eff_addr = 16'h0000;
    imm      = 16'h0000;
    err      = 1'b0;
    case (mode)
      cpu_decode_pkg::m_work: begin
        eff_addr = {12'h000, b1[7:4]};
      end
      cpu_decode_pkg::m_work_bit: begin
        eff_addr = {12'h000, b1[7:4]};
      end
      cpu_decode_pkg::m_reg: begin
        eff_addr = {8'h00, b1};
      end
      cpu_decode_pkg::m_reg_pair: begin
        eff_addr = {8'h00, b1};
        err      = b1[0];
      end
      cpu_decode_pkg::m_ind_addr: begin
        eff_addr = {8'h00, b1};
        err      = b1[0];
      end
      cpu_decode_pkg::m_ind_pair: begin
        eff_addr = opnd_val;
        err      = b1[0];
      end
      cpu_decode_pkg::m_indexed: begin
        eff_addr = {8'h00, 8'(b2 + opnd_val[7:0])};
      end
      cpu_decode_pkg::m_short_idx: begin
        eff_addr = 16'(opnd_val + disp8);
        err      = b1[0];
      end
      cpu_decode_pkg::m_long_idx: begin
        eff_addr = 16'(opnd_val + {b3, b2});
        err      = b1[0];
      end
      cpu_decode_pkg::m_direct: begin
        eff_addr = {b1, b2};
      end
      cpu_decode_pkg::m_relative: begin
        eff_addr = 16'(pc_next + disp8);
      end
      cpu_decode_pkg::m_imm_byte: begin
        imm = {8'h00, b2};
      end
      cpu_decode_pkg::m_imm_long: begin
        imm = {b2, b3};
        err = b1[0];
      end
      default: begin
        eff_addr = 16'h0000;
      end
    endcase
  end

endmodule
`default_nettype wire

// File: design/operand_decode_flags.sv
`timescale 1ns/1ps
`default_nettype none
module operand_decode_flags (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire cpu_decode_pkg::axil_req_s axil_req,
  output var  cpu_decode_pkg::axil_rsp_s axil_rsp,
  input  wire logic                      fast_irq_enter,
  input  wire logic                      irq_req,
  output var  logic                      irq_grant,
  output var  logic                      bank_sel,
  output var  logic                      fast_irq_active,
  output var  logic                      fast_ret,
  output var  logic                      normal_ret
);

  typedef struct packed {
    logic                                  aw_have;
    logic [cpu_decode_pkg::ADDR_W-1:0]     aw_addr;
    logic                                  w_have;
    logic [31:0]                           w_data;
    logic [3:0]                            w_strb;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  rvalid;
    logic [31:0]                           rdata;
    logic [1:0]                            rresp;
    logic [7:0]                            flags;
    logic [31:0]                           instr;
    logic [31:0]                           opnd;
    logic                                  go;
    cpu_decode_pkg::dec_s                  dec;
    logic [31:0]                           addr_word;
    logic                                  fast_ret;
    logic                                  normal_ret;
  } state_s;

  state_s                s_q;
  state_s                s_d;
  cpu_decode_pkg::dec_s  dec_c;
  cpu_decode_pkg::alu_e  alu_c;
  logic [7:0]            opc;
  logic [7:0]            b1;
  logic [7:0]            b2;
  logic [7:0]            b3;
  logic [3:0]            hi;
  logic [3:0]            lo;
  logic [15:0]           eff_c;
  logic [15:0]           imm_c;
  logic                  err_c;
  logic [31:0]           wmask;

  assign opc = s_q.instr[7:0];
  assign b1  = s_q.instr[15:8];
  assign b2  = s_q.instr[23:16];
  assign b3  = s_q.instr[31:24];
  assign hi  = opc[7:4];
  assign lo  = opc[3:0];

  // Byte-lane mask from the write strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{s_q.w_strb[gi]}};
    end
  endgenerate

  // ALU operation from the upper nibble
  always_comb begin
    case (hi)
      4'h0: alu_c = cpu_decode_pkg::alu_add;
      4'h1: alu_c = cpu_decode_pkg::alu_adc;
      4'h2: alu_c = cpu_decode_pkg::alu_sub;
      4'h3: alu_c = cpu_decode_pkg::alu_sbc;
      4'h4: alu_c = cpu_decode_pkg::alu_or;
      4'h5: alu_c = cpu_decode_pkg::alu_and;
      4'h6: alu_c = cpu_decode_pkg::alu_tcm;
      4'h7: alu_c = cpu_decode_pkg::alu_tm;
      4'hA: alu_c = cpu_decode_pkg::alu_cp;
      4'hB: alu_c = cpu_decode_pkg::alu_xor;
      default: alu_c = cpu_decode_pkg::alu_none;
    endcase
  end

  // Operand decode of the lower-nibble 0 to 7 half of the opcode map
  always_comb begin
    dec_c        = '0;
    dec_c.mode   = cpu_decode_pkg::m_none;
    dec_c.alu    = cpu_decode_pkg::alu_none;
    dec_c.form   = cpu_decode_pkg::f_none;
    dec_c.wreg   = b1[7:4];
    if (lo < 4'h8) begin
      dec_c.valid = 1'b1;
    end
    if (lo >= 4'h2 && lo <= 4'h6 && alu_c != cpu_decode_pkg::alu_none) begin
      dec_c.alu = alu_c;
      case (lo)
        4'h2: begin
          dec_c.form = cpu_decode_pkg::f_work_work;
          dec_c.mode = cpu_decode_pkg::m_work;
        end
        4'h3: begin
          dec_c.form = cpu_decode_pkg::f_work_ind;
          dec_c.mode = cpu_decode_pkg::m_work;
        end
        4'h4: begin
          dec_c.form = cpu_decode_pkg::f_reg_reg;
          dec_c.mode = cpu_decode_pkg::m_reg;
        end
        4'h5: begin
          dec_c.form = cpu_decode_pkg::f_ind_reg;
          dec_c.mode = cpu_decode_pkg::m_reg;
        end
        default: begin
          dec_c.form = cpu_decode_pkg::f_reg_imm;
          dec_c.mode = cpu_decode_pkg::m_imm_byte;
        end
      endcase
    end else if (lo == 4'h0 || lo == 4'h1) begin
      // Word increment and decrement take a pair in their direct form
      if (lo == 4'h0 && (hi == 4'h8 || hi == 4'hA)) begin
        dec_c.mode = cpu_decode_pkg::m_reg_pair;
      end else begin
        dec_c.mode = cpu_decode_pkg::m_reg;
      end
    end else if (lo == 4'h7) begin
      case (hi)
        4'h3: begin
          dec_c.mode   = cpu_decode_pkg::m_relative;
          dec_c.bitpos = b1[3:1];
        end
        4'h8, 4'h9: dec_c.mode = cpu_decode_pkg::m_indexed;
        4'hA, 4'hB: dec_c.mode = cpu_decode_pkg::m_long_idx;
        4'hC, 4'hD: dec_c.mode = cpu_decode_pkg::m_work;
        4'hE, 4'hF: dec_c.mode = cpu_decode_pkg::m_short_idx;
        default: begin
          dec_c.mode   = cpu_decode_pkg::m_work_bit;
          dec_c.bitpos = b1[3:1];
        end
      endcase
    end else if (lo < 4'h8) begin
      case (opc)
        cpu_decode_pkg::OPC_CPIJE,
        cpu_decode_pkg::OPC_CPIJNE:   dec_c.mode = cpu_decode_pkg::m_relative;
        cpu_decode_pkg::OPC_CALL_IA:  dec_c.mode = cpu_decode_pkg::m_ind_addr;
        cpu_decode_pkg::OPC_CALL_IRR: dec_c.mode = cpu_decode_pkg::m_ind_pair;
        cpu_decode_pkg::OPC_CALL_DA:  dec_c.mode = cpu_decode_pkg::m_direct;
        cpu_decode_pkg::OPC_LDW_IML:  dec_c.mode = cpu_decode_pkg::m_imm_long;
        cpu_decode_pkg::OPC_LDW_RR:   dec_c.mode = cpu_decode_pkg::m_reg_pair;
        default: begin
          if (lo == 4'h6) begin
            dec_c.mode = cpu_decode_pkg::m_imm_byte;
          end else begin
            dec_c.mode = cpu_decode_pkg::m_reg;
          end
        end
      endcase
    end
    // A working-register byte in the register-pair mode takes its register number from the lower nibble
    if (dec_c.mode == cpu_decode_pkg::m_reg_pair && b1[7:4] == cpu_decode_pkg::WREG_PREFIX) begin
      dec_c.wreg = b1[3:0];
    end
  end

  operand_address_unit u_addr (
    .mode     (dec_c.mode),
    .b1       (b1),
    .b2       (b2),
    .b3       (b3),
    .opnd_val (s_q.opnd[15:0]),
    .pc_next  (s_q.opnd[31:16]),
    .eff_addr (eff_c),
    .imm      (imm_c),
    .err      (err_c)
  );

  always_comb begin
    s_d            = s_q;
    s_d.go         = 1'b0;
    s_d.fast_ret   = 1'b0;
    s_d.normal_ret = 1'b0;

    // Write address and data are taken independently, either order
    if (axil_req.awvalid && !s_q.aw_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !s_q.w_have && !s_q.bvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = axil_req.wdata;
      s_d.w_strb = axil_req.wstrb;
    end
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = cpu_decode_pkg::RESP_OKAY;
      case (s_q.aw_addr)
        cpu_decode_pkg::OFF_INSTR: begin
          s_d.instr = (s_q.instr & ~wmask) | (s_q.w_data & wmask);
          s_d.go    = 1'b1;
        end
        cpu_decode_pkg::OFF_OPND: begin
          s_d.opnd = (s_q.opnd & ~wmask) | (s_q.w_data & wmask);
        end
        cpu_decode_pkg::OFF_DECODE,
        cpu_decode_pkg::OFF_ADDR: begin
          s_d.bresp = cpu_decode_pkg::RESP_OKAY;
        end
        cpu_decode_pkg::OFF_FLAGS: begin
          if (s_q.w_strb[0]) begin
            s_d.flags = s_q.w_data[7:0];
          end
        end
        default: begin
          s_d.bresp = cpu_decode_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.bvalid && axil_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (axil_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = cpu_decode_pkg::RESP_OKAY;
      case (axil_req.araddr)
        cpu_decode_pkg::OFF_INSTR:  s_d.rdata = s_q.instr;
        cpu_decode_pkg::OFF_OPND:   s_d.rdata = s_q.opnd;
        cpu_decode_pkg::OFF_DECODE: s_d.rdata = {12'h000, s_q.dec};
        cpu_decode_pkg::OFF_ADDR:   s_d.rdata = s_q.addr_word;
        cpu_decode_pkg::OFF_FLAGS:  s_d.rdata = {24'h000000, s_q.flags};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = cpu_decode_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && axil_req.rready) begin
      s_d.rvalid = 1'b0;
    end

    // Results and flag effects land one cycle after the instruction write
    if (s_q.go) begin
      s_d.dec       = dec_c;
      // Error joins here so the mode decode does not loop through the address unit
      s_d.dec.err   = err_c;
      s_d.addr_word = {imm_c, eff_c};
      case (opc)
        cpu_decode_pkg::OPC_INTERRUPT_RETURN_INSTR: begin
          if (s_q.flags[cpu_decode_pkg::FLAG_FIS]) begin
            s_d.fast_ret = 1'b1;
            s_d.flags[cpu_decode_pkg::FLAG_FIS] = 1'b0;
          end else begin
            s_d.normal_ret = 1'b1;
          end
        end
        cpu_decode_pkg::OPC_SB0: s_d.flags[cpu_decode_pkg::FLAG_BANK] = 1'b0;
        cpu_decode_pkg::OPC_SB1: s_d.flags[cpu_decode_pkg::FLAG_BANK] = 1'b1;
        default: s_d.go = 1'b0;
      endcase
    end

    // Entry is applied last so it wins over any clear in the same cycle
    if (fast_irq_enter) begin
      s_d.flags[cpu_decode_pkg::FLAG_FIS] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.flags <= cpu_decode_pkg::FLAGS_RESET;
      s_q.instr <= cpu_decode_pkg::INSTR_RESET;
      s_q.opnd  <= cpu_decode_pkg::OPND_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Ready is withheld while a taken beat waits or a response is pending
  always_comb begin
    axil_rsp         = '0;
    axil_rsp.awready = !s_q.aw_have && !s_q.bvalid;
    axil_rsp.wready  = !s_q.w_have && !s_q.bvalid;
    axil_rsp.bvalid  = s_q.bvalid;
    axil_rsp.bresp   = s_q.bresp;
    axil_rsp.arready = !s_q.rvalid;
    axil_rsp.rvalid  = s_q.rvalid;
    axil_rsp.rdata   = s_q.rdata;
    axil_rsp.rresp   = s_q.rresp;
  end

  always_comb begin
    irq_grant       = irq_req && !s_q.flags[cpu_decode_pkg::FLAG_FIS];
    bank_sel        = s_q.flags[cpu_decode_pkg::FLAG_BANK];
    fast_irq_active = s_q.flags[cpu_decode_pkg::FLAG_FIS];
    fast_ret        = s_q.fast_ret;
    normal_ret      = s_q.normal_ret;
  end

endmodule
`default_nettype wire

// File: bench/operand_decode_flags_props.sv
`timescale 1ns/1ps
`default_nettype none
module operand_decode_flags_props (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      ce,
  input wire cpu_decode_pkg::axil_req_s axil_req,
  input wire cpu_decode_pkg::axil_rsp_s axil_rsp,
  input wire logic                      fast_irq_enter,
  input wire logic                      irq_req,
  input wire logic                      irq_grant,
  input wire logic                      bank_sel,
  input wire logic                      fast_irq_active,
  input wire logic                      fast_ret,
  input wire logic                      normal_ret
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  irq_block_a: assert property (irq_grant == (irq_req && !fast_irq_active))
    else $error("irq grant disagrees with fast flag");
  fis_set_a: assert property (ce && fast_irq_enter |=> fast_irq_active)
    else $error("fast flag not set on entry");
  // Software writes to the flags may also move the fast flag
  fis_rise_a: assert property ($past(rst_n) && $rose(fast_irq_active) |->
      $past(fast_irq_enter) || axil_rsp.bvalid || $past(axil_rsp.bvalid))
    else $error("fast flag rose without cause");
  fis_fall_a: assert property ($past(rst_n) && $fell(fast_irq_active) |->
      fast_ret || axil_rsp.bvalid || $past(axil_rsp.bvalid))
    else $error("fast flag fell without return");
  fast_path_a: assert property ($rose(fast_ret) |-> $past(fast_irq_active) && !normal_ret)
    else $error("fast return without fast flag");
  normal_path_a: assert property ($rose(normal_ret) |-> !$past(fast_irq_active))
    else $error("normal return while fast flag set");
  ret_pulse_a: assert property (fast_ret && ce |=> !fast_ret)
    else $error("fast return pulse too long");
  bank_change_a: assert property ($past(rst_n) && $changed(bank_sel) |->
      axil_rsp.bvalid || $past(axil_rsp.bvalid))
    else $error("bank select moved without a write");
endmodule

bind operand_decode_flags operand_decode_flags_props i_props (
  .clk(clk), .rst_n(rst_n), .ce(ce), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .fast_irq_enter(fast_irq_enter), .irq_req(irq_req), .irq_grant(irq_grant), .bank_sel(bank_sel),
  .fast_irq_active(fast_irq_active), .fast_ret(fast_ret), .normal_ret(normal_ret));
`default_nettype wire

// File: bench/tb_cpu_operand_decode_and_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_operand_decode_and_flags;
  logic                      clk;
  logic                      rst_n;
  logic                      ce;
  logic                      fast_irq_enter;
  logic                      irq_req;
  cpu_decode_pkg::axil_req_s req;
  cpu_decode_pkg::axil_rsp_s rsp;
  logic                      irq_grant;
  logic                      bank_sel;
  logic                      fast_irq_active;
  logic                      fast_ret;
  logic                      normal_ret;
  logic [31:0]               rd;
  logic [31:0]               dec;
  logic [31:0]               adr;
  logic [1:0]                rs;
  logic [7:0]                b1;
  logic [7:0]                b2;
  logic [7:0]                opc;
  logic [15:0]               pc;
  logic [15:0]               v;
  logic [3:0]                ups [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB};
  logic [7:0]                pair_ops [4] = '{8'hD4, 8'hF4, 8'hC4, 8'hC6};
  int                        errors;
  int                        tests_run;
  int                        cyc;
  int                        fast_cnt;
  int                        norm_cnt;
  int                        k;

  operand_decode_flags i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .axil_req(req), .axil_rsp(rsp),
    .fast_irq_enter(fast_irq_enter), .irq_req(irq_req), .irq_grant(irq_grant), .bank_sel(bank_sel),
    .fast_irq_active(fast_irq_active), .fast_ret(fast_ret), .normal_ret(normal_ret));

  always #4 clk = ~clk;

  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    cyc++;
    if (fast_ret === 1'b1) fast_cnt++;
    if (normal_ret === 1'b1) norm_cnt++;
    if (cyc > 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic tend(input string n);
    $display("Test %s finished", n);
  endtask

  // Response is sampled mid-cycle, so it reflects the value at the coming edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ha, hw, hb;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk);
      ha = req.awvalid && rsp.awready;
      hw = req.wvalid && rsp.wready;
      hb = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge clk);
      if (ha) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    logic hr, hv;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    hv = 1'b0;
    while (!hv) begin
      @(negedge clk);
      hr = req.arvalid && rsp.arready;
      hv = rsp.rvalid;
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge clk);
      if (hr) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
  endtask

  task automatic run_op(input logic [7:0] op, c1, c2, c3, input logic [15:0] npc, val);
    wr(cpu_decode_pkg::OFF_OPND, {npc, val}, 4'hF);
    wr(cpu_decode_pkg::OFF_INSTR, {c3, c2, c1, op}, 4'hF);
    rd_reg(cpu_decode_pkg::OFF_DECODE);
    dec = rd;
    rd_reg(cpu_decode_pkg::OFF_ADDR);
    adr = rd;
  endtask

  // Alu field, form field and valid bit of the decode word
  function automatic logic [14:0] exp_alu(input logic [7:0] op);
    logic [3:0] a;
    a = (op[7:4] == 4'hA) ? 4'h8 : (op[7:4] == 4'hB) ? 4'h9 : op[7:4];
    return {a, 3'(op[3:0] - 4'h1), 8'h01};
  endfunction

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    fast_irq_enter = 1'b0;
    irq_req = 1'b0;
    req = '0;
    void'($urandom(32'h5C65A428));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(cpu_decode_pkg::OFF_FLAGS);
    chk("flags reset", 32'h0000_0000, rd);
    rd_reg(cpu_decode_pkg::OFF_INSTR);
    chk("instr reset", 32'h0000_00FF, rd);
    rd_reg(cpu_decode_pkg::OFF_DECODE);
    chk("decode reset", 32'h0000_0000, rd);
    tend("reset");
    wr(cpu_decode_pkg::OFF_FLAGS, 32'h0000_00F1, 4'hF);
    wr(cpu_decode_pkg::OFF_FLAGS, 32'h0000_0000, 4'hE);
    rd_reg(cpu_decode_pkg::OFF_FLAGS);
    chk("flags write", 32'h0000_00F1, rd);
    run_op(8'h4F, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
    chk_bit("bank zero", 1'b0, bank_sel);
    chk_bit("unmapped op valid", 1'b0, dec[0]);
    rd_reg(cpu_decode_pkg::OFF_FLAGS);
    chk("flags after bank zero", 32'h0000_00F0, rd);
    run_op(8'h5F, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
    chk_bit("bank one", 1'b1, bank_sel);
    tend("bank");
    irq_req <= 1'b1;
    fast_irq_enter <= 1'b1;
    @(posedge clk);
    fast_irq_enter <= 1'b0;
    @(negedge clk);
    chk_bit("fast flag set", 1'b1, fast_irq_active);
    chk_bit("irq blocked", 1'b0, irq_grant);
    k = fast_cnt;
    wr(cpu_decode_pkg::OFF_INSTR, 32'h0000_00BF, 4'hF);
    rd_reg(cpu_decode_pkg::OFF_FLAGS);
    chk("fast return count", k + 1, fast_cnt);
    chk_bit("fast flag cleared", 1'b0, rd[1]);
    chk_bit("irq granted", 1'b1, irq_grant);
    k = norm_cnt;
    wr(cpu_decode_pkg::OFF_INSTR, 32'h0000_00BF, 4'hF);
    rd_reg(cpu_decode_pkg::OFF_FLAGS);
    chk("normal return count", k + 1, norm_cnt);
    // A frozen core must ignore the entry pulse
    @(posedge clk);
    ce <= 1'b0;
    fast_irq_enter <= 1'b1;
    @(posedge clk);
    fast_irq_enter <= 1'b0;
    ce <= 1'b1;
    @(negedge clk);
    chk_bit("frozen fast flag", 1'b0, fast_irq_active);
    tend("fast interrupt");
    for (k = 0; k < 30; k++) begin
      b1 = 8'($urandom);
      opc = {ups[$urandom_range(9)], 4'($urandom_range(6, 2))};
      run_op(opc, b1, 8'($urandom), 8'($urandom), 16'($urandom), 16'($urandom));
      chk("alu decode", 32'(exp_alu(opc)), 32'(dec[14:0] & 15'h7F01));
    end
    tend("alu rows");
    for (k = 0; k < 8; k++) begin
      b1 = {7'($urandom), k[0]};
      b2 = 8'($urandom);
      run_op(pair_ops[k / 2], b1, b2, 8'h3C, 16'h0000, 16'h0000);
      chk_bit("pair parity error", k[0], dec[19]);
      if (k / 2 == 3) chk("long immediate", {b2, 8'h3C}, 32'(adr[31:16]));
    end
    tend("pair operands");
    for (k = 0; k < 6; k++) begin
      b2 = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'($urandom);
      pc = (k == 2) ? 16'h0000 : 16'($urandom);
      v = 16'($urandom);
      run_op(8'hC2, 8'h00, b2, 8'h00, pc, v);
      chk("relative target", 32'(16'(pc + {{8{b2[7]}}, b2})), 32'(adr[15:0]));
      run_op(8'h87, 8'h12, b2, 8'h00, pc, v);
      chk("indexed address", {24'h0, 8'(b2 + v[7:0])}, 32'(adr[15:0]));
      b1 = 8'($urandom);
      run_op(8'hE7, b1, b2, b1, pc, v);
      chk("short indexed", 32'(16'(v + {{8{b2[7]}}, b2})), 32'(adr[15:0]));
      chk_bit("short indexed pair", b1[0], dec[19]);
      run_op(8'hA7, b1, b2, b1, pc, v);
      chk("long indexed", 32'(16'(v + {b1, b2})), 32'(adr[15:0]));
      run_op(8'h57, b1, b2, b1, pc, v);
      chk("bit register", 32'(b1[7:4]), adr);
      chk("bit position", 32'(b1[3:1]), 32'(dec[3:1]));
      run_op(8'h00, b1, b2, b1, pc, v);
      chk("register operand", 32'(b1), adr);
    end
    tend("address modes");
    wr(12'h100, 32'h1234_5678, 4'hF);
    chk("unmapped write resp", 32'(cpu_decode_pkg::RESP_SLVERR), 32'(rs));
    rd_reg(12'h100);
    chk("unmapped read resp", 32'(cpu_decode_pkg::RESP_SLVERR), 32'(rs));
    chk("unmapped read data", 32'h0, rd);
    rd_reg(cpu_decode_pkg::OFF_DECODE);
    dec = rd;
    wr(cpu_decode_pkg::OFF_DECODE, 32'hFFFF_FFFF, 4'hF);
    chk("read only resp", 32'(cpu_decode_pkg::RESP_OKAY), 32'(rs));
    rd_reg(cpu_decode_pkg::OFF_DECODE);
    chk("read only kept", dec, rd);
    tend("bus errors");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_bit("bank after reset", 1'b0, bank_sel);
    tend("second reset");
    end_sim();
  end
endmodule
`default_nettype wire
